// ### bus_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef BUS_CTRL_MAP_SVH
`define BUS_CTRL_MAP_SVH
/////////////////////////////////////////////////////////////////////
// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_DR0 8'h04
`define OFF_DR1 8'h08
`define OFF_DR2 8'h0C
`define OFF_DR3 8'h10
`define OFF_BPEN 8'h14
`define OFF_REQ 8'h18
`define OFF_STATUS 8'h1C
`define OFF_ISTAT 8'h20
`define OFF_IMASK 8'h24
`define OFF_MCADDR 8'h28
/////////////////////////////////////////////////////////////////////
// Control fields
`define CTRL_MCE 0
`define CTRL_SEL0 1
`define CTRL_SEL1 2
`define CTRL_RST 3'h0
// Event bits
`define EV_DONE 0
`define EV_BACKOFF_N 1
`define EV_BCHK 2
`define EV_BP 3
`define EV_RST 4'h0
/////////////////////////////////////////////////////////////////////
// Timing
`define COLD_RESET_MS 1
`define CLOCK_HZ 20000000
`define COLD_RESET_CYCLES ((`COLD_RESET_MS * `CLOCK_HZ) / 1000)
`endif

// ### bus_ctrl_pkg.sv
// Types shared by the bus control modules
package bus_ctrl_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    data_phase_state,
    pipelined_addr_data_state,
    pipelined_data_state,
    st_hold
  } bus_state_t;

  typedef struct packed {
    logic [28:0] addr;
    logic wr;
  } cyc_t;
endpackage

// ### bp_if.sv
// Carrier between the top and the breakpoint matcher
`timescale 1ns/1ps
interface bp_if;
  logic [28:0] addr;
  logic strobe;
  logic [3:0][28:0] dr;
  logic [3:0] en;
  logic [3:0] match;
  modport host (output addr, output strobe, output dr, output en, input match);
  modport unit (input addr, input strobe, input dr, input en, output match);
endinterface

// ### bp_match.sv
// Debug address comparators, one per debug address register
`timescale 1ns/1ps
module bp_match (
  input wire logic clk_i,
  input wire logic rst_n_i,
  bp_if.unit bp
);
  typedef struct packed {
    logic [3:0] match;
  } bp_state_t;

  bp_state_t r;
  bp_state_t n;

  always_comb begin
    n = r;
    for (int i = 0; i < 4; i++) begin
      n.match[i] = bp.strobe & bp.en[i] & (bp.addr == bp.dr[i]);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bp.match = r.match;
endmodule // bp_match

// ### ratio_capture.sv
// Bus ratio strap capture, reloaded only by a cold reset
`timescale 1ns/1ps
`include "bus_ctrl_map.svh"
module ratio_capture #(
  parameter int COLD_CYCLES = `COLD_RESET_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic core_reset_i,
  input wire logic [1:0] ratio_sel_i,
  output logic [1:0] ratio_o,
  output logic valid_o
);
  localparam int CW = $clog2(COLD_CYCLES + 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [1:0] samp;
    logic prev;
    logic [1:0] ratio;
    logic valid;
  } rc_state_t;

  rc_state_t r;
  rc_state_t n;

  always_comb begin
    n = r;
    n.prev = core_reset_i;
    if (core_reset_i) begin
      n.samp = ratio_sel_i;
      if (r.cnt != CW'(COLD_CYCLES)) begin
        n.cnt = r.cnt + CW'(1);
      end
    end else if (r.prev) begin
      if (r.cnt == CW'(COLD_CYCLES)) begin
        n.ratio = r.samp;
        n.valid = 1'b1;
      end
      n.cnt = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign ratio_o = r.ratio;
  assign valid_o = r.valid;
endmodule // ratio_capture

// ### bus_ctrl_top.sv
// Processor bus control: ratio strap, backoff, ready, request, bus check, breakpoints
//
// Notes on behaviour
// - Sample ratio strap during reset
// - Only cold reset reloads the ratio
// - Backoff aborts cycles, floats pins next clock
// - Hold during backoff, then restart cycles whole
// - Breakpoint output per matching debug register
// - Select bits pick breakpoint or monitor function
// - Shared pins are monitor outputs after reset
// - Sample ready only in data states
// - Duplicate ready acts like ready
// - Bus request always driven, shows pending request
// - Bus check captures cycle address and type
// - Machine check enable raises the exception
// - Stop clock defers bus check; snoop may lose it
`timescale 1ns/1ps
`include "bus_ctrl_map.svh"
module bus_ctrl_top
  import bus_ctrl_pkg::*;
#(
  parameter int COLD_CYCLES = `COLD_RESET_CYCLES
) (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic CORE_RESET_I,
  input wire logic [1:0] BUS_RATIO_SELECT_I,
  input wire logic BACKOFF_N_I,
  input wire logic BURST_READY_N_I,
  input wire logic BURST_READY_DUP_N_I,
  input wire logic BUS_CHECK_N_I,
  input wire logic STOP_CLOCK_N_I,
  input wire logic SNOOP_SAME_LINE_I,
  output logic [28:0] ADDR_O,
  output logic WRITE_O,
  output logic ADDR_STROBE_N_O,
  output logic BUS_OE_O,
  output logic BUS_REQUEST_O,
  output logic [1:0] BREAKPOINT_OUT_HIGH_O,
  output logic [1:0] PERFMON_BREAKPOINT_OUT_O,
  output logic MACHINE_CHECK_O,
  output logic IRQ_O,
  output logic [1:0] BUS_RATIO_O
);
  /////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  /////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    bus_state_t st;
    cyc_t s0;
    cyc_t s1;
    logic v0;
    logic v1;
    logic ads;
    cyc_t out;
    logic oe;
    logic bus_request;
    logic [2:0] ctrl;
    logic [3:0][28:0] dr;
    logic [3:0] bpen;
    logic [3:0] istat;
    logic [3:0] imask;
    logic irq;
    cyc_t mc;
    logic mc_pend;
    logic exc;
    logic [1:0] bp_high;
    logic [1:0] pmbp;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } top_state_t;

  top_state_t r;
  top_state_t n;

  logic [1:0] ratio;
  logic ratio_valid;
  logic wr_acc;
  logic sample;
  logic rdy;
  logic chk;
  logic retire;
  logic take;
  logic [3:0] ev;
  logic [1:0] pm;
  logic [3:0] w1c;
  logic hit;

  bp_if bp ();

  /////////////////////////////////////////////////////////////////////
  // Submodules
  ratio_capture #(
    .COLD_CYCLES(COLD_CYCLES)
  ) u_ratio (
    .clk_i(CLOCK_I),
    .rst_n_i(rst_n),
    .core_reset_i(CORE_RESET_I),
    .ratio_sel_i(BUS_RATIO_SELECT_I),
    .ratio_o(ratio),
    .valid_o(ratio_valid)
  );

  bp_match u_bp (
    .clk_i(CLOCK_I),
    .rst_n_i(rst_n),
    .bp(bp.unit)
  );

  assign bp.addr = r.out.addr;
  assign bp.strobe = r.ads;
  assign bp.dr = r.dr;
  assign bp.en = r.bpen;

  /////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic [31:0] rd_word(input top_state_t s, input logic [7:0] a,
                                          input logic [1:0] rt, input logic rv);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (is_reg(a, `OFF_CTRL)) d = {29'h0000_0000, s.ctrl};
    if (is_reg(a, `OFF_DR0)) d = {s.dr[0], 3'h0};
    if (is_reg(a, `OFF_DR1)) d = {s.dr[1], 3'h0};
    if (is_reg(a, `OFF_DR2)) d = {s.dr[2], 3'h0};
    if (is_reg(a, `OFF_DR3)) d = {s.dr[3], 3'h0};
    if (is_reg(a, `OFF_BPEN)) d = {28'h000_0000, s.bpen};
    if (is_reg(a, `OFF_REQ)) d = {s.s0.addr, 2'h0, s.s0.wr};
    if (is_reg(a, `OFF_STATUS)) begin
      d = {22'h00_0000, rv, rt, s.mc_pend, s.v1, s.v0, 1'b0, s.st};
    end
    if (is_reg(a, `OFF_ISTAT)) d = {28'h000_0000, s.istat};
    if (is_reg(a, `OFF_IMASK)) d = {28'h000_0000, s.imask};
    if (is_reg(a, `OFF_MCADDR)) d = {s.mc.addr, 2'h0, s.mc.wr};
    return d;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `OFF_MCADDR);
  endfunction

  /////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = r;
    wr_acc = PSEL_I & PENABLE_I & r.pready & PWRITE_I;
    sample = (r.st == data_phase_state) | (r.st == pipelined_data_state)
           | (r.st == pipelined_addr_data_state);
    rdy = sample & ~(BURST_READY_N_I & BURST_READY_DUP_N_I);
    chk = sample & ~BUS_CHECK_N_I;
    retire = 1'b0;
    take = 1'b0;
    ev = `EV_RST;
    pm = 2'h0;
    w1c = 4'h0;
    hit = 1'b0;
    n.ads = 1'b0;

    // Bus cycle sequencer
    if (CORE_RESET_I) begin
      n.st = st_idle;
      n.v0 = 1'b0;
      n.v1 = 1'b0;
      n.oe = 1'b1;
    end else if (!BACKOFF_N_I) begin
      if (r.st != st_idle && r.st != st_hold) begin
        ev[`EV_BACKOFF_N] = 1'b1;
        pm[1] = 1'b1;
      end
      n.st = st_hold;
      n.oe = 1'b0;
    end else begin
      n.oe = 1'b1;
      unique case (r.st)
        st_idle, st_hold: begin
          if (r.v0) begin
            n.st = st_addr;
            n.ads = 1'b1;
            n.out = r.s0;
          end else begin
            n.st = st_idle;
          end
        end
        st_addr: begin
          n.st = data_phase_state;
        end
        data_phase_state: begin
          if (rdy) begin
            retire = 1'b1;
            if (r.v1) begin
              n.st = st_addr;
              n.ads = 1'b1;
              n.out = r.s1;
            end else begin
              n.st = st_idle;
            end
          end else if (r.v1) begin
            n.st = pipelined_addr_data_state;
            n.ads = 1'b1;
            n.out = r.s1;
          end
        end
        pipelined_addr_data_state: begin
          if (rdy) begin
            retire = 1'b1;
            n.st = data_phase_state;
          end else begin
            n.st = pipelined_data_state;
          end
        end
        pipelined_data_state: begin
          if (rdy) begin
            retire = 1'b1;
            n.st = data_phase_state;
          end
        end
      endcase
    end

    if (retire) begin
      n.s0 = r.s1;
      n.v0 = r.v1;
      n.v1 = 1'b0;
      ev[`EV_DONE] = 1'b1;
      pm[0] = 1'b1;
    end

    // Bus check and machine check
    if (chk) begin
      n.mc = r.s0;
      ev[`EV_BCHK] = 1'b1;
      if (!STOP_CLOCK_N_I) begin
        n.mc_pend = 1'b1;
      end else begin
        take = 1'b1;
      end
    end else if (r.mc_pend) begin
      if (STOP_CLOCK_N_I) begin
        n.mc_pend = 1'b0;
        take = 1'b1;
      end else if (SNOOP_SAME_LINE_I) begin
        n.mc_pend = 1'b0;
      end
    end
    n.exc = take & r.ctrl[`CTRL_MCE];

    // Breakpoint and monitor pins
    ev[`EV_BP] = |bp.match;
    n.bp_high = bp.match[3:2];
    n.pmbp[0] = r.ctrl[`CTRL_SEL0] ? bp.match[0] : pm[0];
    n.pmbp[1] = r.ctrl[`CTRL_SEL1] ? bp.match[1] : pm[1];

    // Register writes
    if (wr_acc) begin
      if (is_reg(PADDR_I, `OFF_CTRL)) n.ctrl = PWDATA_I[2:0];
      if (is_reg(PADDR_I, `OFF_DR0)) n.dr[0] = PWDATA_I[31:3];
      if (is_reg(PADDR_I, `OFF_DR1)) n.dr[1] = PWDATA_I[31:3];
      if (is_reg(PADDR_I, `OFF_DR2)) n.dr[2] = PWDATA_I[31:3];
      if (is_reg(PADDR_I, `OFF_DR3)) n.dr[3] = PWDATA_I[31:3];
      if (is_reg(PADDR_I, `OFF_BPEN)) n.bpen = PWDATA_I[3:0];
      if (is_reg(PADDR_I, `OFF_IMASK)) n.imask = PWDATA_I[3:0];
      if (is_reg(PADDR_I, `OFF_ISTAT)) w1c = PWDATA_I[3:0];
      hit = is_reg(PADDR_I, `OFF_REQ) & ~CORE_RESET_I;
    end
    if (hit) begin
      if (!n.v0) begin
        n.s0 = {PWDATA_I[31:3], PWDATA_I[0]};
        n.v0 = 1'b1;
      end else if (!n.v1) begin
        n.s1 = {PWDATA_I[31:3], PWDATA_I[0]};
        n.v1 = 1'b1;
      end
    end

    // Sticky events, set wins over clear
    n.istat = (r.istat & ~w1c) | ev;
    n.irq = |(n.istat & n.imask);
    n.bus_request = n.v0 | n.v1;

    // Bus slave answer, one wait-free access phase
    if (PSEL_I & ~PENABLE_I & ~r.pready) begin
      n.pready = 1'b1;
      n.pslverr = ~mapped(PADDR_I);
      n.prdata = rd_word(r, PADDR_I, ratio, ratio_valid);
    end else begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
    end
  end

  /////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= st_idle;
      r.oe <= 1'b1;
      r.ctrl <= `CTRL_RST;
      r.istat <= `EV_RST;
      r.imask <= `EV_RST;
    end else begin
      r <= n;
    end
  end

  /////////////////////////////////////////////////////////////////////
  // Outputs
  assign PRDATA_O = r.prdata;
  assign PREADY_O = r.pready;
  assign PSLVERR_O = r.pslverr;
  assign ADDR_O = r.out.addr;
  assign WRITE_O = r.out.wr;
  assign ADDR_STROBE_N_O = ~r.ads;
  assign BUS_OE_O = r.oe;
  assign BUS_REQUEST_O = r.bus_request;
  assign BREAKPOINT_OUT_HIGH_O = r.bp_high;
  assign PERFMON_BREAKPOINT_OUT_O = r.pmbp;
  assign MACHINE_CHECK_O = r.exc;
  assign IRQ_O = r.irq;
  assign BUS_RATIO_O = ratio;
endmodule // bus_ctrl_top

// ### bus_ctrl_props.sv
// Port assertions of the bus control block
`timescale 1ns/1ps
module bus_ctrl_props (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic CORE_RESET_I,
  input wire logic BACKOFF_N_I,
  input wire logic STOP_CLOCK_N_I,
  input wire logic ADDR_STROBE_N_O,
  input wire logic BUS_OE_O,
  input wire logic BUS_REQUEST_O,
  input wire logic [1:0] BREAKPOINT_OUT_HIGH_O,
  input wire logic MACHINE_CHECK_O,
  input wire logic [1:0] BUS_RATIO_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);
  logic [1:0] up_r;
  logic up;
  assign up = (up_r == 2'h3);
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) up_r <= 2'h0;
    else if (!up) up_r <= up_r + 2'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence req_up;
    $rose(BUS_REQUEST_O) && BACKOFF_N_I && BUS_OE_O;
  endsequence
  sequence bo_rel;
    $rose(BACKOFF_N_I) ##1 BACKOFF_N_I;
  endsequence
  req_driven_a: assert property (!ADDR_STROBE_N_O |-> $past(BUS_REQUEST_O))
    else $error("strobe without request");
  req_start_a: assert property ((up and req_up) |=> !ADDR_STROBE_N_O)
    else $error("request without strobe");
  backoff_float_a: assert property (up && !BACKOFF_N_I |=> !BUS_OE_O)
    else $error("pins not floated");
  hold_quiet_a: assert property (!BUS_OE_O |-> ADDR_STROBE_N_O)
    else $error("strobe in hold");
  hold_end_a: assert property ((up and bo_rel) |-> ##[0:2] BUS_OE_O)
    else $error("hold kept");
  mc_stop_a: assert property (MACHINE_CHECK_O |-> $past(STOP_CLOCK_N_I))
    else $error("check during stop clock");
  mc_pulse_a: assert property (MACHINE_CHECK_O |=> !MACHINE_CHECK_O)
    else $error("check pulse too long");
  ratio_keep_a: assert property (!CORE_RESET_I && !$past(CORE_RESET_I)
    && !$past(CORE_RESET_I, 2) |-> $stable(BUS_RATIO_O))
    else $error("ratio moved");
  bp_time_a: assert property (|BREAKPOINT_OUT_HIGH_O |-> $past(ADDR_STROBE_N_O, 2) == 1'b0)
    else $error("breakpoint without strobe");
endmodule // bus_ctrl_props

// ### sys_model.sv
// System bus controller answering the device cycles
`timescale 1ns/1ps
module sys_model (
  input wire logic clk_i,
  input wire logic strobe_n_i,
  input wire logic abort_i,
  input wire logic [3:0] wait_i,
  input wire logic dup_i,
  input wire logic chk_i,
  output logic ready_n_o,
  output logic dup_n_o,
  output logic check_n_o
);
  int pend = 0;
  int cnt = 0;
  initial {ready_n_o, dup_n_o, check_n_o} = 3'h7;
  // Ready after the programmed wait, one per strobe
  always @(posedge clk_i) begin
    ready_n_o <= 1'b1;
    dup_n_o <= 1'b1;
    check_n_o <= 1'b1;
    if (abort_i) begin
      pend = 0;
      cnt = 0;
    end else begin
      if (!strobe_n_i) pend++;
      if (pend > 0 && cnt >= wait_i) begin
        if (dup_i) dup_n_o <= 1'b0;
        else ready_n_o <= 1'b0;
        check_n_o <= !chk_i;
        pend--;
        cnt = 0;
      end else if (pend > 0) cnt++;
    end
  end
endmodule // sys_model

// ### test_bus_ctrl_top.sv
// Testbench of the bus control block
`timescale 1ns/1ps
module test_bus_ctrl_top;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, core_rst = 0;
  logic backoff_n_n = 1, stop_n = 1, snoop = 0, dup = 0, chk = 0, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, prdata;
  logic [1:0] ratio_sel = 0, bph, pm, ratio;
  logic [3:0] wt = 0;
  logic pready, pslverr, stb_n, oe, bus_request, mc, irq, wrt, rdy_n, rdyd_n, bchk_n;
  logic [28:0] addr;
  logic [4:0] seen = 0;
  int nstb = 0, fails = 0, compares = 0, cyc = 0, n, s0;
  bus_ctrl_top #(.COLD_CYCLES(8)) dut (.CLOCK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .CORE_RESET_I(core_rst),
    .BUS_RATIO_SELECT_I(ratio_sel), .BACKOFF_N_I(backoff_n_n), .BURST_READY_N_I(rdy_n),
    .BURST_READY_DUP_N_I(rdyd_n), .BUS_CHECK_N_I(bchk_n), .STOP_CLOCK_N_I(stop_n),
    .SNOOP_SAME_LINE_I(snoop), .ADDR_O(addr), .WRITE_O(wrt), .ADDR_STROBE_N_O(stb_n),
    .BUS_OE_O(oe), .BUS_REQUEST_O(bus_request), .BREAKPOINT_OUT_HIGH_O(bph),
    .PERFMON_BREAKPOINT_OUT_O(pm), .MACHINE_CHECK_O(mc), .IRQ_O(irq), .BUS_RATIO_O(ratio));
  sys_model sys (.clk_i(clk), .strobe_n_i(stb_n), .abort_i(!backoff_n_n), .wait_i(wt), .dup_i(dup),
    .chk_i(chk), .ready_n_o(rdy_n), .dup_n_o(rdyd_n), .check_n_o(bchk_n));
  initial forever #25 clk = ~clk;
  always @(negedge clk) begin
    seen = seen | {mc, bph, pm};
    if (stb_n === 1'b0) nstb++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task complete_run();
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task run(input logic [31:0] a, input logic w);
    seen = 0;
    apb(1, 8'h18, {a[31:3], 2'b00, w});
    n = 0;
    while (bus_request !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    check(32'(bus_request), 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_ratio();
    ratio_sel <= 2'h2;
    core_rst <= 1;
    repeat (10) @(posedge clk);
    core_rst <= 0;
    repeat (3) @(posedge clk);
    check(32'(ratio), 2);
    ratio_sel <= 2'h1;
    @(posedge clk) core_rst <= 1;
    repeat (3) @(posedge clk);
    core_rst <= 0;
    repeat (3) @(posedge clk);
    check(32'(ratio), 2);
  endtask
  task t_cycles();
    apb(0, 8'h00, 0);
    check(rd, 0);
    apb(0, 8'h40, 0);
    check(32'(err), 1);
    for (int i = 0; i < 4; i++) begin
      dup <= i[0];
      wt <= 4'(i[1] * 2);
      run(32'h1000_0000 + i * 8, i[0]);
      check({addr, wrt}, {29'(32'h0200_0000 + i), i[0]});
      check(32'(seen[0]), 1);
      apb(0, 8'h20, 0);
      check(rd & 1, 1);
      apb(1, 8'h20, 32'hF);
    end
  endtask
  task t_pipe();
    s0 = nstb;
    wt <= 4'h4;
    apb(1, 8'h18, 32'h4000_0010);
    check(32'(bus_request), 1);
    run(32'h4000_0020, 0);
    check(nstb - s0, 2);
    check(32'(addr), 32'h0800_0004);
  endtask
  task t_backoff();
    s0 = nstb;
    wt <= 4'h6;
    apb(1, 8'h18, 32'h5000_0000);
    repeat (3) @(posedge clk);
    backoff_n_n <= 0;
    repeat (2) @(posedge clk);
    check(32'(oe), 0);
    check(32'(seen[1]), 1);
    repeat (3) @(posedge clk);
    backoff_n_n <= 1;
    run(32'h5000_0008, 0);
    check(nstb - s0, 3);
    apb(0, 8'h20, 0);
    check(rd & 2, 2);
  endtask
  task t_bp();
    apb(1, 8'h0C, 32'h2000_0040);
    apb(1, 8'h14, 32'h4);
    run(32'h2000_0040, 0);
    check(32'(seen[2]), 1);
    apb(1, 8'h00, 32'h2);
    apb(1, 8'h04, 32'h2000_0080);
    apb(1, 8'h14, 32'h1);
    run(32'h2000_00C0, 0);
    check(32'(seen[0]), 0);
    run(32'h2000_0080, 0);
    check(32'(seen[0]), 1);
  endtask
  task t_check();
    apb(1, 8'h00, 32'h1);
    apb(1, 8'h24, 32'h4);
    chk <= 1;
    run(32'h3000_0008, 1);
    check(32'(seen[4]), 1);
    apb(0, 8'h28, 0);
    check(rd, 32'h3000_0009);
    check(32'(irq), 1);
    apb(1, 8'h20, 32'h4);
    check(32'(irq), 0);
    stop_n <= 0;
    run(32'h3000_0010, 1);
    check(32'(seen[4]), 0);
    stop_n <= 1;
    chk <= 0;
    repeat (3) @(posedge clk);
    check(32'(seen[4]), 1);
    chk <= 1;
    stop_n <= 0;
    run(32'h3000_0018, 1);
    snoop <= 1;
    @(posedge clk) snoop <= 0;
    stop_n <= 1;
    chk <= 0;
    repeat (3) @(posedge clk);
    check(32'(seen[4]), 0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    t_ratio();
    t_cycles();
    t_pipe();
    t_backoff();
    t_bp();
    t_check();
    complete_run();
  end
endmodule // test_bus_ctrl_top
bind bus_ctrl_top bus_ctrl_props u_props (.*);
